// ---- include/pinsel_pkg.sv ----
/*
 * Shared constants for the port H to L pin-function select block: register offsets,
 * mode field layout, power-on reset values and the per-port pin capability masks.
 * Assumes it is compiled before every file that names it.
 */
package pinsel_pkg;

   localparam int REG_W = 16;
   localparam int PINS = 8;
   localparam int FIELD_W = 2;
   localparam int PORTS = 4;

   // Word-aligned byte offsets on the register bus.
   localparam logic [3:0] OFS_PORT_H = 4'h0;
   localparam logic [3:0] OFS_PORT_J = 4'h4;
   localparam logic [3:0] OFS_PORT_K = 4'h8;
   localparam logic [3:0] OFS_PORT_L = 4'hC;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 3;

   // Order of ports within the packed pin vectors, eight bits each.
   localparam int SLOT_H = 0;
   localparam int SLOT_J = 1;
   localparam int SLOT_K = 2;
   localparam int SLOT_L = 3;

   localparam int PIN7_FIELD_LSB = 14;
   localparam int PIN6_FIELD_LSB = 12;

   localparam logic [15:0] RST_PORT_H_STRAP_HI = 16'hAAAA;
   localparam logic [15:0] RST_PORT_H_STRAP_LO = 16'h8AAA;
   localparam logic [15:0] RST_PORT_J = 16'h0000;
   localparam logic [15:0] RST_PORT_K = 16'h0000;
   localparam logic [15:0] RST_PORT_L = 16'h0000;

   typedef enum logic [1:0] {
      MODE_ALT = 2'h0,
      MODE_OUT = 2'h1,
      MODE_PU_ON = 2'h2,
      MODE_PU_OFF = 2'h3
   } pin_mode_t;

   // Pins whose code 00 reaches an alternate function, packed L,K,J,H.
   localparam logic [31:0] ALT_MASKS = {8'hFF, 8'hFF, 8'hCD, 8'hFF};
   // Pins whose code 01 gives a port output, packed L,K,J,H.
   localparam logic [31:0] OUT_MASKS = {8'h00, 8'hFF, 8'hFF, 8'h80};

endpackage

// ---- include/pin_mode_if.sv ----
/*
 * Carrier between the register file and one port's mode decoder: the stored mode word
 * goes out, the registered per-pin controls come back.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface pin_mode_if;
   logic [15:0] mode_word;
   logic [7:0] alt_sel;
   logic [7:0] out_en;
   logic [7:0] pullup_en;
   logic [7:0] reserved;

   modport ctrl (
      output mode_word,
      input alt_sel,
      input out_en,
      input pullup_en,
      input reserved
   );

   modport decode (
      input mode_word,
      output alt_sel,
      output out_en,
      output pullup_en,
      output reserved
   );
endinterface

// ---- design/pin_mode_decode.sv ----
/*
 * Decodes one port's sixteen-bit mode word into per-pin controls, registered.
 * Assumes the masks name which pins own an alternate function and a port output.
 */
`timescale 1ns/10ps
module pin_mode_decode #(
   parameter logic [7:0] ALT_MASK = 8'hFF,
   parameter logic [7:0] OUT_MASK = 8'hFF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   pin_mode_if.decode pm
);

   logic [7:0] next_alt;
   logic [7:0] next_oe;
   logic [7:0] next_pu;
   logic [7:0] next_rsv;

   always_comb begin
      next_alt = 8'h00;
      next_oe = 8'h00;
      next_pu = 8'h00;
      next_rsv = 8'h00;
      for (int n = 0; n < pinsel_pkg::PINS; n++) begin
         unique case (pm.mode_word[pinsel_pkg::FIELD_W*n +: pinsel_pkg::FIELD_W])
            pinsel_pkg::MODE_ALT: begin
               // A pin without an alternate function treats code 00 as reserved.
               next_alt[n] = ALT_MASK[n];
               next_rsv[n] = ~ALT_MASK[n];
            end
            pinsel_pkg::MODE_OUT: begin
               next_oe[n] = OUT_MASK[n];
               next_rsv[n] = ~OUT_MASK[n];
            end
            pinsel_pkg::MODE_PU_ON: begin
               next_pu[n] = 1'b1;
            end
            pinsel_pkg::MODE_PU_OFF: begin
               next_pu[n] = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pm.alt_sel <= 8'h00;
         pm.out_en <= 8'h00;
         pm.pullup_en <= 8'h00;
         pm.reserved <= 8'h00;
      end else if (ce_i) begin
         pm.alt_sel <= next_alt;
         pm.out_en <= next_oe;
         pm.pullup_en <= next_pu;
         pm.reserved <= next_rsv;
      end
   end

endmodule

// ---- design/port_h_to_l_pin_function_select.sv ----
/*
 * Pin-function select registers for ports H, J, K and L behind a classic Wishbone slave,
 * with registered per-pin alternate, output, pull-up and reserved controls.
 * Assumes inputs synchronous to clk_i and rst_i as the power-on reset.
 */
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps

module port_h_to_l_pin_function_select #(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic manual_reset_i,
   input wire logic standby_i,
   input wire logic sleep_i,
   input wire logic debug_mode_strap_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic [31:0] pin_alt_sel_o,
   output logic [31:0] pin_out_en_o,
   output logic [31:0] pin_pullup_en_o,
   output logic [31:0] pin_reserved_o,
   output logic debug_mode_latched_o,
   output logic low_power_o
);

   logic [15:0] port_h;
   logic [15:0] port_j;
   logic [15:0] port_k;
   logic [15:0] port_l;
   logic [15:0] next_port_h;
   logic [15:0] next_port_j;
   logic [15:0] next_port_k;
   logic [15:0] next_port_l;
   logic ack;
   logic next_ack;
   logic [31:0] rd_data;
   logic [31:0] next_rd_data;
   logic strap_latched;
   logic low_power;
   logic next_low_power;
   logic req;
   logic mapped;
   logic wr_take;
   logic [1:0] idx;
   logic [15:0] sel_reg;

   pin_mode_if pm [pinsel_pkg::PORTS] ();

   assign req = cyc_i & stb_i & ~ack;
   assign idx = adr_i[pinsel_pkg::IDX_MSB:pinsel_pkg::IDX_LSB];
   // Only whole, aligned words in the low sixteen bytes decode; the rest read as zero.
   assign mapped = (adr_i[ADR_W-1:4] == '0) && (adr_i[1:0] == 2'h0);
   // A write needs both low byte lanes, so a mode word is never left half-updated.
   assign wr_take = req & we_i & mapped & (sel_i[1:0] == 2'h3) & ~manual_reset_i;

   always_comb begin
      unique case (idx)
         pinsel_pkg::OFS_PORT_H[3:2]: sel_reg = port_h;
         pinsel_pkg::OFS_PORT_J[3:2]: sel_reg = port_j;
         pinsel_pkg::OFS_PORT_K[3:2]: sel_reg = port_k;
         pinsel_pkg::OFS_PORT_L[3:2]: sel_reg = port_l;
      endcase
   end

   always_comb begin
      next_port_h = port_h;
      next_port_j = port_j;
      next_port_k = port_k;
      next_port_l = port_l;
      if (wr_take) begin
         unique case (idx)
            pinsel_pkg::OFS_PORT_H[3:2]: next_port_h = dat_i[15:0];
            pinsel_pkg::OFS_PORT_J[3:2]: next_port_j = dat_i[15:0];
            pinsel_pkg::OFS_PORT_K[3:2]: next_port_k = dat_i[15:0];
            pinsel_pkg::OFS_PORT_L[3:2]: next_port_l = dat_i[15:0];
         endcase
      end
   end

   always_comb begin
      // Manual reset only stalls a bus cycle in flight, holding off ack and the write; it never touches the registers.
      next_ack = req & ~manual_reset_i;
      next_rd_data = rd_data;
      if (req & ~we_i) begin
         next_rd_data = mapped ? {16'h0000, sel_reg} : 32'h0000_0000;
      end
      next_low_power = standby_i | sleep_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // The strap pin is sampled on every reset cycle; the last one before release wins.
         strap_latched <= debug_mode_strap_i;
         port_h <= debug_mode_strap_i ? pinsel_pkg::RST_PORT_H_STRAP_HI
                                      : pinsel_pkg::RST_PORT_H_STRAP_LO;
         port_j <= pinsel_pkg::RST_PORT_J;
         port_k <= pinsel_pkg::RST_PORT_K;
         port_l <= pinsel_pkg::RST_PORT_L;
         ack <= 1'b0;
         rd_data <= 32'h0000_0000;
         low_power <= 1'b0;
      end else if (ce_i) begin
         // Standby and sleep are only reported; the mode words keep their contents.
         port_h <= next_port_h;
         port_j <= next_port_j;
         port_k <= next_port_k;
         port_l <= next_port_l;
         ack <= next_ack;
         rd_data <= next_rd_data;
         low_power <= next_low_power;
      end
   end

   assign pm[pinsel_pkg::SLOT_H].mode_word = port_h;
   assign pm[pinsel_pkg::SLOT_J].mode_word = port_j;
   assign pm[pinsel_pkg::SLOT_K].mode_word = port_k;
   assign pm[pinsel_pkg::SLOT_L].mode_word = port_l;

   // Each port differs only in which pins own an alternate function and an output.
   for (genvar g = 0; g < pinsel_pkg::PORTS; g++) begin : g_port
      pin_mode_decode #(
         .ALT_MASK(pinsel_pkg::ALT_MASKS[8*g +: 8]),
         .OUT_MASK(pinsel_pkg::OUT_MASKS[8*g +: 8])
      ) u_decode (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .pm(pm[g])
      );
      assign pin_alt_sel_o[8*g +: 8] = pm[g].alt_sel;
      assign pin_out_en_o[8*g +: 8] = pm[g].out_en;
      assign pin_pullup_en_o[8*g +: 8] = pm[g].pullup_en;
      assign pin_reserved_o[8*g +: 8] = pm[g].reserved;
   end

   assign dat_o = rd_data;
   assign ack_o = ack;
   assign debug_mode_latched_o = strap_latched;
   assign low_power_o = low_power;

   default clocking cb @(posedge clk_i);
   endclocking

   // Views of the packed outputs used by the checks below.
   logic [7:0] h_oe;
   logic [7:0] h_rsv;
   logic [7:0] h_alt;
   logic [7:0] h_pu;
   logic [7:0] j_alt;
   logic [7:0] j_rsv;
   logic [7:0] k_oe;
   logic [7:0] l_oe;
   logic [7:0] l_rsv;
   assign h_oe = pin_out_en_o[8*pinsel_pkg::SLOT_H +: 8];
   assign h_rsv = pin_reserved_o[8*pinsel_pkg::SLOT_H +: 8];
   assign h_alt = pin_alt_sel_o[8*pinsel_pkg::SLOT_H +: 8];
   assign h_pu = pin_pullup_en_o[8*pinsel_pkg::SLOT_H +: 8];
   assign j_alt = pin_alt_sel_o[8*pinsel_pkg::SLOT_J +: 8];
   assign j_rsv = pin_reserved_o[8*pinsel_pkg::SLOT_J +: 8];
   assign k_oe = pin_out_en_o[8*pinsel_pkg::SLOT_K +: 8];
   assign l_oe = pin_out_en_o[8*pinsel_pkg::SLOT_L +: 8];
   assign l_rsv = pin_reserved_o[8*pinsel_pkg::SLOT_L +: 8];

   a_strap_high_reset: assert property (
      rst_i && debug_mode_strap_i |=> port_h == 16'hAAAA && strap_latched
   ) else $error("port H reset value wrong with strap high");

   a_strap_low_reset: assert property (
      rst_i && !debug_mode_strap_i |=> port_h == 16'h8AAA && !debug_mode_latched_o
   ) else $error("port H reset value wrong with strap low");

   a_jkl_reset_zero: assert property (
      rst_i |=> port_j == 16'h0000 && port_k == 16'h0000 && port_l == 16'h0000
   ) else $error("port J, K or L did not reset to zero");

   a_keep_manual_lowpwr: assert property (
      disable iff (rst_i)
      (manual_reset_i || standby_i || sleep_i) && !wr_take
         |=> $stable(port_h) && $stable(port_j) && $stable(port_k) && $stable(port_l)
   ) else $error("register changed under manual reset or low power");

   sequence s_write_h;
      ce_i && wr_take && idx == 2'h0;
   endsequence

   sequence s_read_back;
      ce_i && req && !we_i && mapped && idx == 2'h0 && !manual_reset_i;
   endsequence

   // The master keeps its strobe low for one cycle after the ack, so the soonest
   // read is taken three edges after the write.
   a_write_read_back: assert property (
      disable iff (rst_i || manual_reset_i)
      s_write_h ##1 !wr_take ##2 s_read_back
         |=> ack_o && dat_o == {16'h0000, $past(dat_i[15:0], 4)}
   ) else $error("read did not return written port H word");

   a_write_full_word: assert property (
      disable iff (rst_i)
      ce_i && wr_take && idx == 2'h2 |=> port_k == $past(dat_i[15:0])
   ) else $error("port K write did not store all sixteen bits");

   a_ack_single: assert property (
      disable iff (rst_i)
      ce_i && req && !manual_reset_i |=> ack_o ##1 (!ack_o || !$past(ce_i))
   ) else $error("acknowledge not a single cycle");

   a_pin7_output: assert property (
      disable iff (rst_i)
      ce_i && port_h[pinsel_pkg::PIN7_FIELD_LSB +: 2] == 2'h1 |=> h_oe[7] && !h_rsv[7]
   ) else $error("port H pin 7 output code not decoded");

   a_pin6_reserved: assert property (
      disable iff (rst_i)
      ce_i && port_h[pinsel_pkg::PIN6_FIELD_LSB +: 2] == 2'h1 |=> h_rsv[6] && !h_oe[6]
   ) else $error("port H pin 6 code 01 not reserved");

   a_porth_no_output: assert property (
      disable iff (rst_i)
      h_oe[6:0] == 7'h00
   ) else $error("port H low pins drove a port output");

   a_porth_pullup: assert property (
      disable iff (rst_i)
      ce_i && port_h[1:0] == 2'h2 |=> h_pu[0] && !h_alt[0]
   ) else $error("port H pin 0 pull-up code not decoded");

   a_portj_reserved: assert property (
      disable iff (rst_i)
      ce_i && port_j[3:0] == 4'h0 |=> j_rsv[1] && !j_alt[1] && j_alt[0] && !j_rsv[0]
   ) else $error("port J code 00 wrongly decoded on pin 0 or 1");

   a_portk_output: assert property (
      disable iff (rst_i)
      ce_i && port_k == 16'h5555 |=> k_oe == 8'hFF
   ) else $error("port K output code not decoded on all pins");

   a_portl_no_output: assert property (
      disable iff (rst_i)
      ce_i && port_l[15:14] == 2'h1 |=> l_oe == 8'h00 && l_rsv[7]
   ) else $error("port L drove a port output");

   a_portl_reset_alt: assert property (
      rst_i ##1 !rst_i && ce_i && !wr_take |=> pin_alt_sel_o[31:24] == 8'hFF
   ) else $error("port L pins not in alternate function after reset");

endmodule

// ---- dv/port_h_to_l_pin_function_select_test.sv ----
/*
 * Self-checking bench for the port H to L pin-function select block: Wishbone reads and
 * writes, expected register and pin-control values worked out from a shadow copy.
 * Assumes the design package is compiled first and the block answers every access.
 */
`timescale 1ns/10ps
module port_h_to_l_pin_function_select_test;
   logic clk_i;
   logic rst_i;
   logic ce_i;
   logic manual_reset_i;
   logic standby_i;
   logic sleep_i;
   logic debug_mode_strap_i;
   logic cyc_i;
   logic stb_i;
   logic we_i;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic ack_o;
   logic [31:0] pin_alt_sel_o;
   logic [31:0] pin_out_en_o;
   logic [31:0] pin_pullup_en_o;
   logic [31:0] pin_reserved_o;
   logic debug_mode_latched_o;
   logic low_power_o;
   int miscompares = 0;
   int n_tests = 0;
   int wait_cycles;
   logic [15:0] shadow [4];
   logic [31:0] rd;
   logic [15:0] pats [6] = '{16'h5555, 16'hFFFF, 16'hAAAA, 16'hE41B, 16'h1BE4, 16'h0000};
   // Pin capability per port, H J K L: which pins own code 00 and code 01.
   logic [7:0] alt_m [4] = '{8'hFF, 8'hCD, 8'hFF, 8'hFF};
   logic [7:0] out_m [4] = '{8'h80, 8'hFF, 8'hFF, 8'h00};

   port_h_to_l_pin_function_select #(.ADR_W(8)) u_port_h_to_l_pin_function_select (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .manual_reset_i(manual_reset_i),
      .standby_i(standby_i), .sleep_i(sleep_i), .debug_mode_strap_i(debug_mode_strap_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_alt_sel_o(pin_alt_sel_o),
      .pin_out_en_o(pin_out_en_o), .pin_pullup_en_o(pin_pullup_en_o),
      .pin_reserved_o(pin_reserved_o), .debug_mode_latched_o(debug_mode_latched_o),
      .low_power_o(low_power_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One classic cycle; the request stays up until ack is sampled, the wait is bounded.
   task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] wd,
                           input logic [3:0] sel, output logic [31:0] rdata);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      dat_i <= wd;
      sel_i <= sel;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      end
      rdata = dat_o;
      wait_cycles = n;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   function automatic logic [31:0] exp_pins(input int kind);
      logic [31:0] v;
      logic [1:0] c;
      int k;
      int kd;
      v = '0;
      for (k = 0; k < 32; k++) begin
         c = shadow[k / 8][2 * (k % 8) +: 2];
         if (c == 2'h0) begin
            kd = alt_m[k / 8][k % 8] ? 0 : 3;
         end else if (c == 2'h1) begin
            kd = out_m[k / 8][k % 8] ? 1 : 3;
         end else begin
            kd = (c == 2'h2) ? 2 : 4;
         end
         v[k] = (kd == kind);
      end
      return v;
   endfunction

   task automatic check_all();
      logic [31:0] r;
      int p;
      for (p = 0; p < 4; p++) begin
         wb_cycle(8'(p * 4), 1'b0, 32'h0, 4'hF, r);
         check(r, {16'h0000, shadow[p]});
      end
      repeat (2) @(posedge clk_i);
      #1;
      check(pin_alt_sel_o, exp_pins(0));
      check(pin_out_en_o, exp_pins(1));
      check(pin_pullup_en_o, exp_pins(2));
      check(pin_reserved_o, exp_pins(3));
   endtask

   // The strap is wrong until the last reset cycle, then flips again once released.
   task automatic do_reset(input logic strap);
      @(posedge clk_i);
      rst_i <= 1'b1;
      debug_mode_strap_i <= ~strap;
      repeat (19) @(posedge clk_i);
      debug_mode_strap_i <= strap;
      @(posedge clk_i);
      rst_i <= 1'b0;
      debug_mode_strap_i <= ~strap;
      shadow = '{strap ? 16'hAAAA : 16'h8AAA, 16'h0000, 16'h0000, 16'h0000};
      repeat (2) @(posedge clk_i);
      #1;
      check({31'h0, debug_mode_latched_o}, {31'h0, strap});
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      stop_test();
   end

   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      manual_reset_i = 1'b0;
      standby_i = 1'b0;
      sleep_i = 1'b0;
      debug_mode_strap_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      do_reset(1'b1);
      check_all();
      $display("test reset_strap_high done");
      for (int i = 0; i < 6; i++) begin
         for (int p = 0; p < 4; p++) begin
            wb_cycle(8'(p * 4), 1'b1, {16'h0000, pats[i] ^ 16'(p * 16'h0101)}, 4'h3, rd);
            shadow[p] = pats[i] ^ 16'(p * 16'h0101);
            check_all();
         end
      end
      $display("test mode_codes done");
      wb_cycle(8'h04, 1'b1, 32'h0000FFFF, 4'h1, rd);
      wb_cycle(8'h10, 1'b1, 32'h0000FFFF, 4'hF, rd);
      wb_cycle(8'h0A, 1'b1, 32'h0000FFFF, 4'hF, rd);
      wb_cycle(8'h08, 1'b1, 32'h00005555, 4'h3, rd);
      wb_cycle(8'h08, 1'b1, 32'hABCD1234, 4'hF, rd);
      shadow[2] = 16'h1234;
      wb_cycle(8'h10, 1'b0, 32'h0, 4'hF, rd);
      check(rd, 32'h00000000);
      wb_cycle(8'h0A, 1'b0, 32'h0, 4'hF, rd);
      check(rd, 32'h00000000);
      check_all();
      $display("test partial_and_unmapped done");
      @(posedge clk_i);
      manual_reset_i <= 1'b1;
      standby_i <= 1'b1;
      sleep_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      check({31'h0, low_power_o}, 32'h1);
      fork
         begin
            repeat (8) @(posedge clk_i);
            manual_reset_i <= 1'b0;
         end
      join_none
      wb_cycle(8'h04, 1'b1, 32'h000000C3, 4'hF, rd);
      shadow[1] = 16'h00C3;
      check(32'(wait_cycles > 4), 32'h1);
      standby_i <= 1'b0;
      sleep_i <= 1'b0;
      check_all();
      check({31'h0, low_power_o}, 32'h0);
      // With the clock enable low the slave must neither answer nor store.
      @(posedge clk_i);
      ce_i <= 1'b0;
      fork
         begin
            repeat (6) @(posedge clk_i);
            ce_i <= 1'b1;
         end
      join_none
      wb_cycle(8'h0C, 1'b1, 32'h000000FF, 4'h3, rd);
      shadow[3] = 16'h00FF;
      check(32'(wait_cycles > 5), 32'h1);
      check_all();
      $display("test manual_reset_low_power done");
      do_reset(1'b0);
      check_all();
      $display("test reset_strap_low done");
      stop_test();
   end
endmodule
